// ### pkg/acms_pkg.sv
// Package for the per-channel mode, interrupt enable and status bank
package acms_pkg;
	localparam int unsigned NUM_CH      = 26;
	localparam int unsigned ADDR_W      = 5;
	localparam int unsigned DATA_W      = 16;
	// Register offsets (word index on the plain register port)
	localparam logic [4:0] OFS_EARLY_IRQ_FLAGS_HI = 5'h00;
	localparam logic [4:0] OFS_MODE0_LO  = 5'h01;
	localparam logic [4:0] OFS_MODE0_HI  = 5'h02;
	localparam logic [4:0] OFS_MODE1_LO  = 5'h03;
	localparam logic [4:0] OFS_MODE1_HI  = 5'h04;
	localparam logic [4:0] OFS_IE_LO     = 5'h05;
	localparam logic [4:0] OFS_IE_HI     = 5'h06;
	localparam logic [4:0] OFS_RDY_LO    = 5'h07;
	localparam logic [4:0] OFS_EARLY_IRQ_ENABLE_LO   = 5'h08;
	localparam logic [4:0] OFS_EARLY_IRQ_ENABLE_HI   = 5'h09;
	localparam logic [4:0] OFS_LEAD_SEL  = 5'h0a;
	localparam logic [4:0] OFS_IRQ_STAT  = 5'h0b;
	localparam logic [4:0] OFS_IRQ_MASK  = 5'h0c;
	// Field positions
	localparam int unsigned MODE_SIGN_BIT = 0;
	localparam int unsigned MODE_DIFFERENTIAL_SELECT_BIT = 1;
	localparam int unsigned HI_CH_BASE    = 16;
	localparam int unsigned HI_CH_CNT     = 10;
	localparam int unsigned LEAD_SEL_W    = 3;
	localparam int unsigned IRQ_EV_W      = 2;
	localparam int unsigned EV_RDY_BIT    = 0;
	localparam int unsigned EV_EARLY_BIT  = 1;
	// Reset values
	localparam logic [15:0] RST_REG16     = 16'h0000;
	localparam logic [2:0]  RST_LEAD_SEL  = 3'h0;
	localparam logic [1:0]  RST_IRQ       = 2'h0;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} acms_req_t;

	typedef struct packed {
		logic [NUM_CH-1:0] differential_select;
		logic [NUM_CH-1:0] sign;
	} acms_mode_t;
endpackage : acms_pkg

// ### hdl/acms_bank.sv
// Per-channel input mode, interrupt enable and conversion status bank
//
// Function
// [RULE1] Each of channels 16..25 sets its early flag on an early interrupt and keeps it until its buffer is read.
// [RULE2] A channel is differential when its differential bit is 1 and single-ended when it is 0.
// [RULE3] A channel's output is signed when its sign bit is 1 and unsigned when it is 0.
// [RULE4] Eight channels share a mode register, differential bit odd above sign bit even; 24 and 25 sit in bits 3..0.
// [RULE5] A channel's enable bit allows both the common and its own interrupt, and a zero suppresses both.
// [RULE6] Enables of channels 16..25 sit in bits 9..0 of the high enable register; bits 15..10 read zero.
// [RULE7] Channels 0..15 show a ready flag while a result waits in their buffer, else zero.
// [RULE8] Ready flags are set and cleared only by hardware; software writes to them do nothing.
// [RULE9] Every mode, enable and status bit clears to zero on reset.
// [RULE10] Bits of absent channels and unused positions read as zero.
// [RULE11] The early interrupt leads data ready by 1 to 8 core clock periods, code 000 to 111.
// [RULE12] An early interrupt only occurs when the channel's early enable is 1.
// [RULE13] The common interrupt is raised while any channel is ready with its enable set.
`timescale 1ns/1ns
`default_nettype none
module acms_bank
	import acms_pkg::*;
#(
	parameter logic [NUM_CH-1:0] CH_PRESENT = {NUM_CH{1'b1}}
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  ce_i,
	input  wire acms_req_t             req_i,
	output logic [DATA_W-1:0]          rdata_o,
	// Converter side, same clock domain
	input  wire logic                  core_tick_i,
	input  wire logic [NUM_CH-1:0]     conv_busy_i,
	input  wire logic [NUM_CH-1:0]     conv_done_i,
	input  wire logic [NUM_CH-1:0]     buf_read_i,
	output acms_mode_t                 mode_o,
	output logic [NUM_CH-1:0]          chan_irq_o,
	output logic [NUM_CH-1:0]          early_irq_o,
	output logic                       common_irq_o,
	output logic                       irq_o
);

	function automatic logic [DATA_W-1:0] pack_mode(input logic [NUM_CH-1:0] d,
		input logic [NUM_CH-1:0] s, input int unsigned base);
		logic [DATA_W-1:0] v;
		v = '0;
		for (int i = 0; i < 8; i++) begin
			if (base + i < NUM_CH) begin
				v[2*i+MODE_DIFFERENTIAL_SELECT_BIT] = d[base+i];
				v[2*i+MODE_SIGN_BIT] = s[base+i];
			end
		end
		return v;
	endfunction : pack_mode

	function automatic logic [DATA_W-1:0] hi_word(input logic [NUM_CH-1:0] v);
		return {6'h00, v[NUM_CH-1:HI_CH_BASE]};
	endfunction : hi_word

	logic [NUM_CH-1:0]     differential_select_r;
	logic [NUM_CH-1:0]     sign_r;
	logic [NUM_CH-1:0]     ie_r;
	logic [NUM_CH-1:0]     early_irq_enable_r;
	logic [NUM_CH-1:0]     early_irq_flags_r;
	logic [NUM_CH-1:0]     rdy_r;
	logic [LEAD_SEL_W-1:0] lead_sel_r;
	logic [IRQ_EV_W-1:0]   irq_stat_r;
	logic [IRQ_EV_W-1:0]   irq_mask_r;
	logic [NUM_CH-1:0]     early_evt;
	logic [NUM_CH-1:0]     rdy_evt;
	logic [3:0]            cnt_r [NUM_CH];
	logic [DATA_W-1:0]     rdata_nxt;
	logic                  wr;
	logic [IRQ_EV_W-1:0]   irq_evt;

	assign wr = ce_i && req_i.wr;

	// Mode registers: two bits per channel, eight channels per word
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			differential_select_r <= '0; // RULE9
			sign_r <= '0;
		end else if (wr) begin
			for (int i = 0; i < 8; i++) begin
				case (req_i.addr)
					OFS_MODE0_LO: begin
						differential_select_r[i]    <= req_i.wdata[2*i+MODE_DIFFERENTIAL_SELECT_BIT]; // RULE4
						sign_r[i]    <= req_i.wdata[2*i+MODE_SIGN_BIT];
					end
					OFS_MODE0_HI: begin
						differential_select_r[8+i]  <= req_i.wdata[2*i+MODE_DIFFERENTIAL_SELECT_BIT];
						sign_r[8+i]  <= req_i.wdata[2*i+MODE_SIGN_BIT];
					end
					OFS_MODE1_LO: begin
						differential_select_r[16+i] <= req_i.wdata[2*i+MODE_DIFFERENTIAL_SELECT_BIT];
						sign_r[16+i] <= req_i.wdata[2*i+MODE_SIGN_BIT];
					end
					OFS_MODE1_HI: begin
						if (i < 2) begin
							differential_select_r[24+i] <= req_i.wdata[2*i+MODE_DIFFERENTIAL_SELECT_BIT]; // RULE4
							sign_r[24+i] <= req_i.wdata[2*i+MODE_SIGN_BIT];
						end
					end
					default: ;
				endcase
			end
		end
	end

	// Enable registers and early lead select
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ie_r       <= '0; // RULE9
			early_irq_enable_r     <= '0;
			lead_sel_r <= RST_LEAD_SEL;
			irq_mask_r <= RST_IRQ;
		end else if (wr) begin
			case (req_i.addr)
				OFS_IE_LO:    ie_r[15:0]              <= req_i.wdata;
				OFS_IE_HI:    ie_r[NUM_CH-1:16]       <= req_i.wdata[HI_CH_CNT-1:0]; // RULE6
				OFS_EARLY_IRQ_ENABLE_LO:  early_irq_enable_r[15:0]            <= req_i.wdata;
				OFS_EARLY_IRQ_ENABLE_HI:  early_irq_enable_r[NUM_CH-1:16]     <= req_i.wdata[HI_CH_CNT-1:0];
				OFS_LEAD_SEL: lead_sel_r              <= req_i.wdata[LEAD_SEL_W-1:0];
				OFS_IRQ_MASK: irq_mask_r              <= req_i.wdata[IRQ_EV_W-1:0];
				default: ;
			endcase
		end
	end

	// Lead counters: count core clock periods while a conversion is busy,
	// firing when the elapsed count matches the selected lead code
	genvar g;
	for (g = 0; g < NUM_CH; g++) begin : g_ch
		always_ff @(posedge clk_i) begin
			// Idle clear is gated by the enable too, so a low ce_i freezes the count
			if (rst_i) begin
				cnt_r[g] <= 4'h0;
			end else if (ce_i && !conv_busy_i[g]) begin
				cnt_r[g] <= 4'h0;
			end else if (ce_i && core_tick_i && cnt_r[g] != 4'hf) begin
				cnt_r[g] <= cnt_r[g] + 4'h1;
			end
		end
	end

	// Converter reports busy with the remaining-period count folded into core_tick;
	// here the early point is taken as the conversion completing lead+1 ticks later,
	// so the event fires on the tick where the count equals the selected lead code
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			early_evt[i] = conv_busy_i[i] && core_tick_i
				&& cnt_r[i] == {1'b0, lead_sel_r} // RULE11
				&& early_irq_enable_r[i] && CH_PRESENT[i]; // RULE12
			rdy_evt[i] = conv_done_i[i] && CH_PRESENT[i];
		end
	end

	// Status flags: set wins over the clear by a buffer read
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			early_irq_flags_r <= '0; // RULE9
			rdy_r    <= '0;
		end else if (ce_i) begin
			early_irq_flags_r <= (early_irq_flags_r & ~buf_read_i) | early_evt; // RULE1
			rdy_r    <= (rdy_r & ~buf_read_i) | rdy_evt; // RULE7 RULE8
		end
	end

	// Sticky interrupt causes, write one to clear
	assign irq_evt[EV_RDY_BIT]   = |(rdy_evt & ie_r);
	assign irq_evt[EV_EARLY_BIT] = |(early_evt & ie_r);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_r <= RST_IRQ;
		end else if (ce_i) begin
			irq_stat_r <= (irq_stat_r & ~((wr && req_i.addr == OFS_IRQ_STAT)
				? req_i.wdata[IRQ_EV_W-1:0] : 2'h0)) | irq_evt;
		end
	end

	// Read decode; absent channels and spare bits read as zero
	always_comb begin
		case (req_i.addr)
			OFS_EARLY_IRQ_FLAGS_HI: rdata_nxt = hi_word(early_irq_flags_r & CH_PRESENT);
			OFS_MODE0_LO:  rdata_nxt = pack_mode(differential_select_r & CH_PRESENT, sign_r & CH_PRESENT, 0); // RULE10
			OFS_MODE0_HI:  rdata_nxt = pack_mode(differential_select_r & CH_PRESENT, sign_r & CH_PRESENT, 8);
			OFS_MODE1_LO:  rdata_nxt = pack_mode(differential_select_r & CH_PRESENT, sign_r & CH_PRESENT, 16);
			OFS_MODE1_HI:  rdata_nxt = pack_mode(differential_select_r & CH_PRESENT, sign_r & CH_PRESENT, 24);
			OFS_IE_LO:     rdata_nxt = ie_r[15:0] & CH_PRESENT[15:0];
			OFS_IE_HI:     rdata_nxt = hi_word(ie_r & CH_PRESENT); // RULE6
			OFS_RDY_LO:    rdata_nxt = rdy_r[15:0] & CH_PRESENT[15:0]; // RULE7
			OFS_EARLY_IRQ_ENABLE_LO:   rdata_nxt = early_irq_enable_r[15:0] & CH_PRESENT[15:0];
			OFS_EARLY_IRQ_ENABLE_HI:   rdata_nxt = hi_word(early_irq_enable_r & CH_PRESENT);
			OFS_LEAD_SEL:  rdata_nxt = {13'h0000, lead_sel_r};
			OFS_IRQ_STAT:  rdata_nxt = {14'h0000, irq_stat_r};
			OFS_IRQ_MASK:  rdata_nxt = {14'h0000, irq_mask_r};
			default:       rdata_nxt = RST_REG16;
		endcase
	end

	// Registered outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o      <= RST_REG16;
			mode_o       <= '0;
			chan_irq_o   <= '0;
			early_irq_o  <= '0;
			common_irq_o <= 1'b0;
			irq_o        <= 1'b0;
		end else if (ce_i) begin
			rdata_o      <= req_i.rd ? rdata_nxt : RST_REG16;
			mode_o.differential_select  <= differential_select_r & CH_PRESENT; // RULE2
			mode_o.sign  <= sign_r & CH_PRESENT; // RULE3
			chan_irq_o   <= rdy_evt & ie_r; // RULE5
			early_irq_o  <= early_evt;
			common_irq_o <= |(rdy_r & ie_r); // RULE13 RULE5
			irq_o        <= |(irq_stat_r & irq_mask_r);
		end
	end

endmodule : acms_bank
`default_nettype wire

// ### test/acms_bank_props.sv
// Port assertions for the mode, enable and status bank
`timescale 1ns/1ns
`default_nettype none
module acms_bank_props
	import acms_pkg::*;
#(
	parameter logic [NUM_CH-1:0] CH_PRESENT = {NUM_CH{1'b1}}
) (
	input wire logic              clk_i,
	input wire logic              rst_i,
	input wire logic              ce_i,
	input wire acms_req_t         req_i,
	input wire logic [DATA_W-1:0] rdata_o,
	input wire acms_mode_t        mode_o,
	input wire logic [NUM_CH-1:0] conv_busy_i,
	input wire logic [NUM_CH-1:0] conv_done_i,
	input wire logic [NUM_CH-1:0] chan_irq_o,
	input wire logic [NUM_CH-1:0] early_irq_o,
	input wire logic              irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence rd_at(logic [4:0] a);
		ce_i && req_i.rd && req_i.addr == a;
	endsequence
	sequence wr_at(logic [4:0] a);
		ce_i && req_i.wr && req_i.addr == a;
	endsequence
	reset_clear_a: assert property ($fell(rst_i) |-> rdata_o == 16'h0000 && mode_o == '0 && !irq_o)
		else $error("state not clear after reset");
	ie_high_zero_a: assert property (rd_at(OFS_IE_HI) |=> rdata_o[15:10] == 6'h00)
		else $error("enable high upper bits set");
	mode_high_zero_a: assert property (rd_at(OFS_MODE1_HI) |=> rdata_o[15:4] == 12'h000)
		else $error("mode high upper bits set");
	early_high_zero_a: assert property (rd_at(OFS_EARLY_IRQ_FLAGS_HI) |=> rdata_o[15:10] == 6'h00)
		else $error("early status upper bits set");
	mode_low_write_a: assert property (wr_at(OFS_MODE0_LO) |-> ##[1:2]
		mode_o.differential_select[0] == ($past(req_i.wdata[1], 2) & CH_PRESENT[0]) && mode_o.sign[0] == ($past(req_i.wdata[0], 2) & CH_PRESENT[0]))
		else $error("channel 0 mode not taken");
	mode_top_write_a: assert property (wr_at(OFS_MODE1_HI) ##1 !req_i.wr |=>
		mode_o.differential_select[25] == ($past(req_i.wdata[3], 2) & CH_PRESENT[25]))
		else $error("channel 25 mode not taken");
	chan_pulse_a: assert property ($past(ce_i) |-> (chan_irq_o & ~$past(conv_done_i)) == '0)
		else $error("channel interrupt without done");
	early_busy_a: assert property ($past(ce_i) |-> (early_irq_o & ~$past(conv_busy_i)) == '0)
		else $error("early interrupt while idle");
endmodule : acms_bank_props
bind acms_bank acms_bank_props #(.CH_PRESENT(CH_PRESENT)) u_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
	.req_i(req_i), .rdata_o(rdata_o), .mode_o(mode_o), .conv_busy_i(conv_busy_i), .conv_done_i(conv_done_i),
	.chan_irq_o(chan_irq_o), .early_irq_o(early_irq_o), .irq_o(irq_o));
`default_nettype wire

// ### test/acms_bank_tb.sv
// Self-checking bench for the mode, enable and status bank
`timescale 1ns/1ns
`default_nettype none
module acms_bank_tb
	import acms_pkg::*;
;
	logic              clk_i = 0, rst_i = 1, ce_i = 1, tick = 0, common_irq_o, irq_o, irq_a;
	acms_req_t         req_i = '0;
	logic [NUM_CH-1:0] busy = '0, done = '0, bufrd = '0, chan_irq_o, early_irq_o;
	logic [DATA_W-1:0] rdata_o;
	acms_mode_t        mode_o;
	int                bad_count = 0, tests_run = 0, i;
	logic [15:0]       exp_w [0:6] = '{16'hffff, 16'hffff, 16'hffff, 16'h000f, 16'hffff, 16'h03ff, 16'h0000};
	acms_bank dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req_i), .rdata_o(rdata_o),
		.core_tick_i(tick), .conv_busy_i(busy), .conv_done_i(done), .buf_read_i(bufrd), .mode_o(mode_o),
		.chan_irq_o(chan_irq_o), .early_irq_o(early_irq_o), .common_irq_o(common_irq_o), .irq_o(irq_o));
	initial forever #5 clk_i = ~clk_i;
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_i);
		req_i <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_i);
		req_i.wr <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge clk_i);
		req_i <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clk_i);
		req_i.rd <= 1'b0;
		#1 check(rdata_o, e);
	endtask : rd
	task automatic step;
		@(posedge clk_i);
		#1;
	endtask : step
	task automatic finish_test;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int a = 0; a < 13; a++) rd(a[4:0], 16'h0000);
		rd(5'h1f, 16'h0000);
		for (int a = 1; a < 8; a++) begin
			wr(a[4:0], 16'hffff);
			rd(a[4:0], exp_w[a-1]);
		end
		check(mode_o.differential_select[25:10] & mode_o.sign[25:10], 16'hffff);
		wr(OFS_MODE0_LO, 16'h0002);
		step();
		check({mode_o.differential_select[1:0], mode_o.sign[1:0]}, 16'h0004);
		wr(OFS_EARLY_IRQ_ENABLE_HI, 16'h0002);
		wr(OFS_LEAD_SEL, 16'h0002);
		@(posedge clk_i);
		busy <= 26'h0060000;
		tick <= 1'b1;
		for (i = 0; i < 40 && early_irq_o[17] !== 1'b1; i++) step();
		if (i == 40) begin
			bad_count++;
			finish_test();
		end
		rd(OFS_EARLY_IRQ_FLAGS_HI, 16'h0002);
		@(posedge clk_i);
		done <= 26'h0060008;
		busy <= '0;
		@(posedge clk_i);
		done <= '0;
		#1 check(chan_irq_o[17], 16'h0001);
		rd(OFS_RDY_LO, 16'h0008);
		check(common_irq_o, 16'h0001);
		rd(OFS_IRQ_STAT, 16'h0003);
		wr(OFS_IRQ_MASK, 16'h0003);
		step();
		irq_a = irq_o;
		wr(OFS_IRQ_MASK, 16'h0000);
		step();
		check(irq_a ^ irq_o, 16'h0001);
		wr(OFS_IRQ_STAT, 16'h0003);
		rd(OFS_IRQ_STAT, 16'h0000);
		check(irq_o, 16'h0000);
		wr(OFS_IE_LO, 16'h0000);
		wr(OFS_IE_HI, 16'h0000);
		step();
		check(common_irq_o, 16'h0000);
		@(posedge clk_i);
		bufrd <= 26'h0020008;
		@(posedge clk_i);
		bufrd <= '0;
		rd(OFS_EARLY_IRQ_FLAGS_HI, 16'h0000);
		rd(OFS_RDY_LO, 16'h0000);
		finish_test();
	end
endmodule : acms_bank_tb
`default_nettype wire
